/* rtl/ppl_framer.sv */
/* Payload packet link framer: telemetry FIFO, packet scheduler with idle gap timing,
   health and status generator, time request issue and ancillary frame screening.
   Assumes a byte-wide transmitter taking one character per strobe, inputs on clock_i. */
// Overview of operation
// - At least five idle character times between the end and start of packets.
// - Once sync is sent, no more than two idle characters before checksum.
// - Every packet starts with the common header words.
// - Header carries the payload's assigned function code.
// - Telemetry carries the secondary header after the common header.
// - Telemetry leaves only inside whole packets, never as loose bytes.
// - Send a time request when faster time updates than thirty seconds are needed.
// - Check the frame identifier, low seven bits of word eight, first.
// - Send a health and status packet once per second.
// - Health and status packet has fixed length and word positions.
// - First health word is the caution word, only zero or one.
// - Second health word is a sixteen-bit unsigned cycle counter.
// - Cycle counter starts at zero, steps by one, wraps to zero.
`timescale 1ns/10ps
`default_nettype none

module ppl_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Fill side
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // Drain side
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic full, next_full, push, pop;
    always_comb begin
        push = in_valid_i && !full;
        pop = out_ready_i && (count != '0);
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        next_full = (next_count == (AW+1)'(DEPTH));
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            full <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            full <= next_full;
        end
    end
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
    assign in_ready_o = !full;
    assign out_data_o = mem[rd_ptr];
    assign out_valid_o = (count != '0);
    assign count_o = count;
endmodule // ppl_fifo

module ppl_framer
    import ppl_pkg::*;
#(
    parameter int CHAR_CYCLES = CHAR_CYCLES_DEF,
    parameter int HS_PERIOD_CYCLES = HS_PERIOD_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Identity and status
    input wire logic [7:0] func_code_i,
    input wire logic caution_advisory_i,
    input wire logic [15:0] hs_status_i,
    input wire logic fast_time_need_i,
    // Telemetry stream in
    input wire logic [15:0] tlm_data_i,
    input wire logic tlm_valid_i,
    output logic tlm_ready_o,
    // Serial characters out
    output logic [7:0] tx_byte_o,
    output logic tx_strobe_o,
    output logic tx_busy_o,
    // Ancillary frames in
    input wire logic [15:0] rx_word_i,
    input wire logic rx_valid_i,
    input wire logic rx_start_i,
    input wire logic [FRAME_IDENTIFIER_BITS-1:0] anc_frame_identifier_i,
    // Ancillary frames out
    output logic [15:0] anc_word_o,
    output logic anc_valid_o,
    output logic anc_reject_o
);
    ppl_state_e state, next_state;
    logic [31:0] slot_cnt, next_slot_cnt, sec_cnt, next_sec_cnt;
    logic [2:0] gap_cnt, next_gap_cnt;
    logic [1:0] kind, next_kind;
    logic [3:0] idx, next_idx, anc_idx, next_anc_idx;
    logic [15:0] sum, next_sum, cyc_cnt, next_cyc_cnt, word, fifo_data;
    logic [7:0] next_tx_byte;
    logic [5:0] fifo_count;
    logic tick, start, hi, next_hi, next_tx_strobe, next_tx_busy;
    logic hs_pend, next_hs_pend, treq_pend, next_treq_pend, need_q;
    logic fifo_valid, fifo_pop, fifo_ready;
    logic anc_match, next_anc_match, next_anc_valid, next_anc_reject;
    function automatic logic [3:0] data_len(input logic [1:0] k);
        case (k)
            KIND_HS: data_len = HS_WORDS;
            KIND_TREQ: data_len = TREQ_WORDS;
            default: data_len = TLM_WORDS;
        endcase
    endfunction
    ppl_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) ppl_fifo_i (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .in_data_i(tlm_data_i),
        .in_valid_i(tlm_valid_i),
        .in_ready_o(fifo_ready),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .count_o(fifo_count)
    );
    // Character slot and one-second timers
    always_comb begin
        tick = (slot_cnt == 32'(CHAR_CYCLES - 1));
        next_slot_cnt = tick ? 32'h0 : slot_cnt + 32'h1;
        next_sec_cnt = (sec_cnt == 32'(HS_PERIOD_CYCLES - 1)) ? 32'h0 : sec_cnt + 32'h1;
    end
    // Word on the line at the current index
    always_comb begin
        if (idx == IDX_SYNC) begin
            word = SYNC_WORD;
        end else if (idx == IDX_HDR) begin
            word = {func_code_i, 6'h00, kind};
        end else if (idx == IDX_LEN) begin
            word = {12'h000, data_len(kind)};
        end else if (idx == IDX_SEC) begin
            word = {14'h0000, kind};
        end else if (idx == 4'(IDX_DATA + data_len(kind))) begin
            word = sum;
        end else if (kind == KIND_HS) begin
            case (4'(idx - IDX_DATA))
                4'h0: word = caution_advisory_i ? CAUTION_ADVISORY : CAUTION_NONE;
                4'h1: word = cyc_cnt;
                default: word = hs_status_i;
            endcase
        end else begin
            word = (kind == KIND_TREQ) ? TREQ_CODE : fifo_data;
        end
    end
    // Transmit scheduler
    always_comb begin
        next_state = state;
        next_gap_cnt = gap_cnt;
        next_kind = kind;
        next_idx = idx;
        next_hi = hi;
        next_sum = sum;
        next_cyc_cnt = cyc_cnt;
        next_tx_byte = tx_byte_o;
        next_tx_strobe = 1'b0;
        fifo_pop = 1'b0;
        start = 1'b0;
        case (state)
            ST_IDLE: begin
                if (tick) begin
                    if (gap_cnt == GAP_CHARS
                        && (hs_pend || treq_pend || fifo_count >= 6'(TLM_WORDS))) begin
                        // Whole telemetry packet is buffered first, so the message never stalls
                        start = 1'b1;
                        next_state = ST_SEND;
                        next_kind = hs_pend ? KIND_HS : (treq_pend ? KIND_TREQ : KIND_TLM);
                        next_idx = IDX_SYNC;
                        next_hi = 1'b0;
                        next_sum = 16'h0000;
                        next_tx_byte = SYNC_WORD[15:8];
                        next_tx_strobe = 1'b1;
                    end else if (gap_cnt != GAP_CHARS) begin
                        next_gap_cnt = 3'(gap_cnt + 3'h1);
                    end
                end
            end
            ST_SEND: begin
                if (tick) begin
                    next_tx_strobe = 1'b1;
                    next_tx_byte = hi ? word[15:8] : word[7:0];
                    next_hi = !hi;
                    if (!hi) begin
                        next_idx = 4'(idx + 4'h1);
                        if (idx == 4'(IDX_DATA + data_len(kind))) begin
                            next_state = ST_IDLE;
                            next_gap_cnt = 3'h0;
                            if (kind == KIND_HS) begin
                                next_cyc_cnt = 16'(cyc_cnt + 16'h1);
                            end
                        end else begin
                            if (idx != IDX_SYNC) begin
                                next_sum = 16'(sum + word);
                            end
                            fifo_pop = (kind == KIND_TLM) && (idx >= IDX_DATA) && fifo_valid;
                        end
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
        next_tx_busy = (next_state == ST_SEND);
        // A new request wins over the clear of a taken one
        next_hs_pend = (hs_pend && !(start && next_kind == KIND_HS))
            || (sec_cnt == 32'(HS_PERIOD_CYCLES - 1));
        next_treq_pend = (treq_pend && !(start && next_kind == KIND_TREQ))
            || (fast_time_need_i && !need_q);
    end
    // Ancillary frame screening
    always_comb begin
        next_anc_idx = anc_idx;
        next_anc_match = anc_match;
        next_anc_valid = 1'b0;
        next_anc_reject = 1'b0;
        if (rx_valid_i) begin
            next_anc_idx = rx_start_i ? 4'h1 : ((anc_idx == 4'hF) ? anc_idx : 4'(anc_idx + 4'h1));
            if (rx_start_i) begin
                next_anc_match = 1'b0;
            end else if (anc_idx == ANC_ID_WORD) begin
                next_anc_match = (rx_word_i[FRAME_IDENTIFIER_BITS-1:0] == anc_frame_identifier_i);
                next_anc_reject = !next_anc_match;
            end else if (anc_idx > ANC_ID_WORD) begin
                next_anc_valid = anc_match;
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
            slot_cnt <= 32'h0;
            sec_cnt <= 32'h0;
            gap_cnt <= GAP_CHARS;
            kind <= KIND_HS;
            idx <= IDX_SYNC;
            hi <= 1'b1;
            sum <= 16'h0000;
            cyc_cnt <= 16'h0000;
            hs_pend <= 1'b1;
            treq_pend <= 1'b0;
            need_q <= 1'b0;
            tx_byte_o <= 8'h00;
            tx_strobe_o <= 1'b0;
            tx_busy_o <= 1'b0;
            tlm_ready_o <= 1'b0;
            anc_idx <= 4'h0;
            anc_match <= 1'b0;
            anc_word_o <= 16'h0000;
            anc_valid_o <= 1'b0;
            anc_reject_o <= 1'b0;
        end else begin
            state <= next_state;
            slot_cnt <= next_slot_cnt;
            sec_cnt <= next_sec_cnt;
            gap_cnt <= next_gap_cnt;
            kind <= next_kind;
            idx <= next_idx;
            hi <= next_hi;
            sum <= next_sum;
            cyc_cnt <= next_cyc_cnt;
            hs_pend <= next_hs_pend;
            treq_pend <= next_treq_pend;
            need_q <= fast_time_need_i;
            tx_byte_o <= next_tx_byte;
            tx_strobe_o <= next_tx_strobe;
            tx_busy_o <= next_tx_busy;
            tlm_ready_o <= fifo_ready;
            anc_idx <= next_anc_idx;
            anc_match <= next_anc_match;
            anc_word_o <= rx_word_i;
            anc_valid_o <= next_anc_valid;
            anc_reject_o <= next_anc_reject;
        end
    end
endmodule // ppl_framer

`default_nettype wire

/* include/ppl_pkg.sv */
/*
 * Constants for the payload packet link framer: timing counts, packet
 * layout, word indices, packet kinds and scheduler states.
 * Assumes a single 250 MHz clock and a byte-wide serial transmitter outside.
 */
`default_nettype none

package ppl_pkg;

    // Timing
    localparam int CLK_HZ = 250_000_000;
    localparam int BAUD_RATE = 115_200;
    localparam int CHAR_BITS = 10;
    // Least time, rounded up to whole cycles
    localparam int CHAR_CYCLES_DEF =
        int'((64'(CLK_HZ) * 64'(CHAR_BITS) + 64'(BAUD_RATE) - 64'd1) / 64'(BAUD_RATE));
    localparam int HS_PERIOD_MS = 1000;
    localparam int HS_PERIOD_CYCLES_DEF = int'(64'(CLK_HZ) * 64'(HS_PERIOD_MS) / 64'd1000);
    localparam logic [2:0] GAP_CHARS = 3'h5;
    localparam logic [2:0] MAX_MSG_IDLE_CHARS = 3'h2;

    // Packet layout
    localparam logic [15:0] SYNC_WORD = 16'hEB90;
    localparam logic [3:0] IDX_SYNC = 4'h0;
    localparam logic [3:0] IDX_HDR = 4'h1;
    localparam logic [3:0] IDX_LEN = 4'h2;
    localparam logic [3:0] IDX_SEC = 4'h3;
    localparam logic [3:0] IDX_DATA = 4'h4;
    localparam logic [3:0] HS_WORDS = 4'h3;
    localparam logic [3:0] TREQ_WORDS = 4'h1;
    localparam logic [3:0] TLM_WORDS = 4'h8;
    localparam logic [15:0] TREQ_CODE = 16'h0003;
    localparam logic [15:0] CAUTION_NONE = 16'h0000;
    localparam logic [15:0] CAUTION_ADVISORY = 16'h0001;

    // Packet kinds
    localparam logic [1:0] KIND_HS = 2'h0;
    localparam logic [1:0] KIND_TREQ = 2'h1;
    localparam logic [1:0] KIND_TLM = 2'h2;

    // Ancillary frame screening
    localparam logic [3:0] ANC_ID_WORD = 4'h7;
    localparam int FRAME_IDENTIFIER_BITS = 7;

    // Buffering
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } ppl_state_e;

endpackage

`default_nettype wire

/* verif/ppl_framer_props.sv */
/* Checker for the framer's serial and ancillary ports.
   Assumes it is bound into ppl_framer with the same slot length. */
`timescale 1ns/10ps
`default_nettype none
module ppl_framer_props
    import ppl_pkg::*;
#(
    parameter int CHAR_CYCLES = 4
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Ancillary side
    input wire logic [15:0] rx_word_i,
    input wire logic rx_valid_i,
    input wire logic rx_start_i,
    input wire logic [FRAME_IDENTIFIER_BITS-1:0] anc_frame_identifier_i,
    input wire logic [15:0] anc_word_o,
    input wire logic anc_valid_o,
    input wire logic anc_reject_o,
    // Serial side
    input wire logic [7:0] tx_byte_o,
    input wire logic tx_strobe_o,
    input wire logic tx_busy_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    int gap;
    logic [4:0] bidx;
    logic [1:0] kind;
    logic [3:0] len;
    logic [3:0] widx;
    logic [3:0] cur;
    logic bad;
    logic last;
    logic w8_bad;
    logic fwd_ok;
    assign cur = rx_start_i ? 4'h1 : (widx == 4'hF ? widx : widx + 4'h1);
    assign last = tx_strobe_o && bidx == 5'({len, 1'b0}) + 5'h09;
    assign w8_bad = rx_valid_i && cur == 4'h8 && rx_word_i[6:0] != anc_frame_identifier_i;
    assign fwd_ok = rx_valid_i && cur >= 4'h9 && !bad;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            gap <= 32'h7FFF_FFFF;
            bidx <= 5'h00;
            kind <= 2'h3;
            len <= 4'h0;
            widx <= 4'h0;
            bad <= 1'b0;
        end else begin
            if (tx_strobe_o) gap <= 1;
            else if (gap != 32'h7FFF_FFFF) gap <= gap + 1;
            if (tx_strobe_o) bidx <= last ? 5'h00 : bidx + 5'h01;
            if (tx_strobe_o && bidx == 5'h03) kind <= tx_byte_o[1:0];
            if (tx_strobe_o && bidx == 5'h05) len <= tx_byte_o[3:0];
            if (rx_valid_i) widx <= cur;
            if (w8_bad) bad <= 1'b1;
            else if (rx_valid_i && rx_start_i) bad <= 1'b0;
        end
    end
    pkt_gap_a: assert property (tx_strobe_o && bidx == 5'h00 |-> gap >= 6 * CHAR_CYCLES)
        else $error("packet started too soon after the previous one");
    msg_idle_a: assert property (tx_strobe_o && bidx != 5'h00 |-> gap <= 3 * CHAR_CYCLES)
        else $error("idle stretch inside a packet");
    sync_head_a: assert property (tx_strobe_o && bidx < 5'h02 |->
        tx_byte_o == (bidx[0] ? SYNC_WORD[7:0] : SYNC_WORD[15:8]))
        else $error("packet does not open with the sync word");
    hs_len_a: assert property (tx_strobe_o && bidx == 5'h05 && kind == KIND_HS |->
        tx_byte_o == {4'h0, HS_WORDS})
        else $error("health packet length wrong");
    caution_val_a: assert property (tx_strobe_o && kind == KIND_HS && bidx[4:1] == 4'h4 |->
        tx_byte_o[7:1] == 7'h00 && (bidx[0] || !tx_byte_o[0]))
        else $error("caution word outside zero and one");
    id_check_a: assert property (w8_bad |=> anc_reject_o)
        else $error("mismatched frame not rejected");
    reject_cause_a: assert property (anc_reject_o |-> $past(w8_bad))
        else $error("reject without a mismatched eighth word");
    fwd_word_a: assert property (anc_valid_o |-> $past(fwd_ok) && anc_word_o == $past(rx_word_i))
        else $error("forwarded word wrong or not allowed");
    busy_flag_a: assert property (tx_strobe_o |-> tx_busy_o == !last)
        else $error("busy flag does not span the packet");
    cover property (tx_strobe_o && bidx == 5'h00);
    cover property (anc_reject_o);
    cover property (anc_valid_o);
endmodule // ppl_framer_props
bind ppl_framer ppl_framer_props #(.CHAR_CYCLES(CHAR_CYCLES)) ppl_framer_props_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .rx_word_i(rx_word_i), .rx_valid_i(rx_valid_i),
    .rx_start_i(rx_start_i), .anc_frame_identifier_i(anc_frame_identifier_i), .anc_word_o(anc_word_o),
    .anc_valid_o(anc_valid_o), .anc_reject_o(anc_reject_o), .tx_byte_o(tx_byte_o),
    .tx_strobe_o(tx_strobe_o), .tx_busy_o(tx_busy_o));
`default_nettype wire

/* verif/ppl_rack_rx.sv */
/* Rack-side serial receiver model: pairs characters into words, high
   byte first, and flags each complete packet. Assumes no line errors. */
`timescale 1ns/10ps
`default_nettype none
module ppl_rack_rx
    import ppl_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Characters from the framer
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_strobe_i,
    // Received packet
    output logic [15:0] words_o [16],
    output logic done_o
);
    logic lo_next;
    logic [7:0] hi_byte;
    logic [4:0] idx;
    always_ff @(posedge clock_i) begin
        done_o <= 1'b0;
        if (sys_rst_i) begin
            lo_next <= 1'b0;
            idx <= 5'h00;
        end else if (tx_strobe_i) begin
            lo_next <= !lo_next;
            hi_byte <= tx_byte_i;
            if (lo_next) begin
                words_o[idx[3:0]] <= {hi_byte, tx_byte_i};
                idx <= idx + 5'h01;
                // Packet ends on the word after its data, length taken from the length word
                if (idx >= 5'(IDX_DATA) && idx == 5'(words_o[IDX_LEN][3:0]) + 5'(IDX_DATA)) begin
                    done_o <= 1'b1;
                    idx <= 5'h00;
                end
            end
        end
    end
endmodule // ppl_rack_rx
`default_nettype wire

/* verif/ppl_framer_tb.sv */
/* Self-checking bench for the payload packet link framer.
   Assumes the rack receiver model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module ppl_framer_tb
    import ppl_pkg::*;
;
    localparam int CC = 4;
    localparam int HSP = 2000;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] func = 8'hA5;
    logic cadv = 1'b0;
    logic [15:0] stat = 16'h5A3C;
    logic need = 1'b0;
    logic [15:0] td = 16'h0000;
    logic tv = 1'b0;
    logic tr;
    logic [15:0] rw = 16'h0000;
    logic rv = 1'b0;
    logic rs = 1'b0;
    logic [6:0] fid = 7'h00;
    logic av;
    logic arj;
    logic [7:0] txb;
    logic txs;
    logic [15:0] w [16];
    logic done;
    logic [15:0] sum;
    int len;
    int d;
    int error_cnt = 0;
    int checks_done = 0;
    int cnt [3] = '{0, 0, 0};
    int tn = 0;
    int cyc = 0;
    int hs_t [4];
    // Ancillary rows: expected id, word eight, reject expected
    logic [23:0] rows [4] = '{{7'h15, 16'hFF15, 1'b0}, {7'h15, 16'h0095, 1'b0},
        {7'h7F, 16'h007E, 1'b1}, {7'h00, 16'h0040, 1'b1}};
    ppl_framer #(.CHAR_CYCLES(CC), .HS_PERIOD_CYCLES(HSP)) ppl_framer_i (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .func_code_i(func), .caution_advisory_i(cadv),
        .hs_status_i(stat), .fast_time_need_i(need), .tlm_data_i(td), .tlm_valid_i(tv),
        .tlm_ready_o(tr), .tx_byte_o(txb), .tx_strobe_o(txs), .tx_busy_o(), .rx_word_i(rw),
        .rx_valid_i(rv), .rx_start_i(rs), .anc_frame_identifier_i(fid), .anc_word_o(),
        .anc_valid_o(av), .anc_reject_o(arj));
    ppl_rack_rx ppl_rack_rx_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .tx_byte_i(txb),
        .tx_strobe_i(txs), .words_o(w), .done_o(done));
    initial begin
        forever #2 clock_i = ~clock_i;
    end
    always @(posedge clock_i) cyc <= cyc + 1;
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wait_cnt(input int k, input int n);
        for (int i = 0; i < 6000 && cnt[k] < n; i++) @(negedge clock_i);
        chk("packet count", 16'(n), 16'(cnt[k]));
        if (cnt[k] < n) close_out();
    endtask
    // Packet monitor on the rack side
    always @(negedge clock_i) begin
        if (done) begin
            len = int'(w[IDX_LEN][3:0]);
            sum = 16'h0000;
            for (int i = 1; i < len + 4; i++) sum += w[i];
            chk("sync", SYNC_WORD, w[0]);
            chk("header", {func, 6'h00, w[1][1:0]}, w[1]);
            chk("secondary", {14'h0000, w[1][1:0]}, w[3]);
            chk("checksum", sum, w[len + 4]);
            case (w[1][1:0])
                KIND_HS: begin
                    chk("hs length", {12'h000, HS_WORDS}, w[IDX_LEN]);
                    chk("caution", {15'h0000, cadv}, w[4]);
                    chk("cycle count", 16'(cnt[0]), w[5]);
                    chk("status", stat, w[6]);
                    if (cnt[0] < 4) hs_t[cnt[0]] = cyc;
                    cnt[0]++;
                end
                KIND_TREQ: begin
                    chk("treq code", TREQ_CODE, w[4]);
                    cnt[1]++;
                end
                KIND_TLM: begin
                    chk("tlm length", {12'h000, TLM_WORDS}, w[IDX_LEN]);
                    for (int i = 0; i < 8; i++) chk("tlm", 16'hA000 + 16'(tn + i), w[4 + i]);
                    tn += 8;
                    cnt[2]++;
                end
                default: chk("kind", 16'h0000, {14'h0000, w[1][1:0]});
            endcase
        end
    end
    initial begin
        repeat (5) @(negedge clock_i);
        chk("strobe in reset", 16'h0000, {15'h0000, txs});
        sys_rst_i = 1'b0;
        foreach (rows[r]) begin
            logic [15:0] nv;
            logic [15:0] nr;
            nv = 16'h0000;
            nr = 16'h0000;
            fid = rows[r][23:17];
            for (int k = 1; k <= 13; k++) begin
                @(negedge clock_i);
                nv = nv + {15'h0000, av};
                nr = nr + {15'h0000, arj};
                rv = k <= 10;
                rs = k == 1;
                rw = k == 8 ? rows[r][16:1] : 16'h1000 + 16'(k);
            end
            chk("forwarded", rows[r][0] ? 16'h0000 : 16'h0002, nv);
            chk("rejected", {15'h0000, rows[r][0]}, nr);
        end
        // Telemetry burst, held until the framer is ready
        tv = 1'b1;
        for (int i = 0; i < 32; i++) begin
            td = 16'hA000 + 16'(i);
            for (int j = 0; j < 500 && tr !== 1'b1; j++) @(negedge clock_i);
            chk("ready", 16'h0001, {15'h0000, tr});
            if (tr !== 1'b1) close_out();
            @(negedge clock_i);
        end
        tv = 1'b0;
        wait_cnt(2, 4);
        need = 1'b1;
        wait_cnt(1, 1);
        need = 1'b0;
        @(negedge clock_i);
        need = 1'b1;
        wait_cnt(1, 2);
        wait_cnt(0, 1);
        cadv = 1'b1;
        wait_cnt(0, 3);
        d = hs_t[2] - hs_t[1];
        chk("hs period", 16'h0001, {15'h0000, d >= HSP - 200 && d <= HSP + 200});
        close_out();
    end
endmodule // ppl_framer_tb
`default_nettype wire
